// ### design/cos_clock_outputs.sv
`timescale 1ns/1ps
`include "cos_clock_regs.svh"
module cos_clock_outputs #(
    parameter int unsigned SEC_TICKS = `COS_SEC_TICKS,
    parameter int unsigned SYNC_TIMEOUT_CYC = `COS_SYNC_TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    input wire logic sync_in,
    input wire logic second_timer_pin_in,
    output logic second_timer_pin_out,
    output logic second_timer_pin_oe,
    output logic rx_dejitter_clock_out,
    output logic tx_dejitter_clock_out,
    output logic one_second_tick
);
    localparam int SEC_W = $clog2(SEC_TICKS);
    localparam int ACT_W = $clog2(SYNC_TIMEOUT_CYC + 1);

    // ****************************************************************
    // Register file.
    // ****************************************************************
    logic [7:0] ctrl_reg;
    logic [3:0] buf_reg;
    logic [10:0] port_reg;
    logic [1:0] pin_reg;
    logic [5:0] gcm_reg;
    logic [31:0] rd_next;
    logic [31:0] status_word;

    wire sel_ctrl = addr == `COS_OFF_CTRL;
    wire sel_buf = addr == `COS_OFF_BUF;
    wire sel_port = addr == `COS_OFF_PORT;
    wire sel_pin = addr == `COS_OFF_PIN;
    wire sel_gcm = addr == `COS_OFF_GCM;
    wire sel_stat = addr == `COS_OFF_STAT;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= `COS_RST_CTRL;
            buf_reg <= `COS_RST_BUF;
            port_reg <= `COS_RST_PORT;
            pin_reg <= `COS_RST_PIN;
            gcm_reg <= `COS_RST_GCM;
        end else if (wr_en) begin
            if (sel_ctrl) begin
                ctrl_reg <= wr_data[7:0];
            end else if (sel_buf) begin
                buf_reg <= wr_data[3:0];
            end else if (sel_port) begin
                port_reg <= wr_data[10:0];
            end else if (sel_pin) begin
                pin_reg <= wr_data[1:0];
            end else if (sel_gcm) begin
                gcm_reg <= wr_data[5:0];
            end
        end
    end

    assign rd_next = !rd_en ? 32'h0 :
                     sel_ctrl ? {24'h0, ctrl_reg} :
                     sel_buf ? {28'h0, buf_reg} :
                     sel_port ? {21'h0, port_reg} :
                     sel_pin ? {30'h0, pin_reg} :
                     sel_gcm ? {26'h0, gcm_reg} :
                     sel_stat ? status_word : 32'h0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= 32'h0;
        end else begin
            rd_data <= rd_next;
        end
    end

    wire master_mode_select = ctrl_reg[`COS_CTRL_MASTER];
    wire sync_8k_select = ctrl_reg[`COS_CTRL_SYNC8K];
    wire oscillator_lock_disable = ctrl_reg[`COS_CTRL_LOCK_DIS];
    wire oscillator_lock_source = ctrl_reg[`COS_CTRL_LOCK_SRC];
    wire t1_mode = ctrl_reg[`COS_CTRL_T1];
    wire rx_clock_source_hi = ctrl_reg[`COS_CTRL_RS_HI];
    wire tx_jitter_atten_off = ctrl_reg[`COS_CTRL_XJA_OFF];
    wire frame_sync_active_low = ctrl_reg[`COS_CTRL_FS_POL];
    wire [1:0] rx_buffer_size = buf_reg[1:0];
    wire [1:0] tx_buffer_size = buf_reg[3:2];
    wire rx_port_enable = port_reg[`COS_PORT_RX_EN];
    wire [3:0] rx_rate_sel = port_reg[`COS_PORT_RX_RATE_LSB +: 4];
    wire tx_port_enable = port_reg[`COS_PORT_TX_EN];
    wire [1:0] tx_rate_sel = port_reg[`COS_PORT_TX_RATE_LSB +: 2];

    // ****************************************************************
    // Oscillators, all stepping on the reference clock.
    // ****************************************************************
    cos_nco_if rx_if ();
    cos_nco_if tx_if ();
    cos_nco_if e1_if ();
    cos_nco_if t1_if ();

    cos_nco u_rx_osc (.clk(clk), .arst_n(arst_n), .nco(rx_if));
    cos_nco u_tx_osc (.clk(clk), .arst_n(arst_n), .nco(tx_if));
    cos_nco u_e1_base (.clk(clk), .arst_n(arst_n), .nco(e1_if));
    cos_nco u_t1_base (.clk(clk), .arst_n(arst_n), .nco(t1_if));

    // The global setup trims both dejitter oscillators in coarse steps of 256 LSB.
    wire [31:0] gcm_trim = {{18{gcm_reg[5]}}, gcm_reg, 8'h00};

    // Even indices below 8 are the E1 rates; in E1 mode an odd index below 8 falls back to the faster E1 rate.
    wire [3:0] rx_idx = rx_rate_sel[3] ? 4'h8 :
                        t1_mode ? rx_rate_sel : {rx_rate_sel[3:1], 1'b0};

    wire [31:0] rx_base_inc = rx_idx == 4'h0 ? `COS_INC(16384000) :
                              rx_idx == 4'h1 ? `COS_INC(12352000) :
                              rx_idx == 4'h2 ? `COS_INC(8192000) :
                              rx_idx == 4'h3 ? `COS_INC(6176000) :
                              rx_idx == 4'h4 ? `COS_INC(4096000) :
                              rx_idx == 4'h5 ? `COS_INC(3088000) :
                              rx_idx == 4'h6 ? `COS_INC(2048000) :
                              rx_idx == 4'h7 ? `COS_INC(1544000) :
                              `COS_INC(8000);

    wire [2:0] tx_idx = {tx_rate_sel, t1_mode};
    wire [31:0] tx_base_inc = tx_idx == 3'h0 ? `COS_INC(16384000) :
                              tx_idx == 3'h1 ? `COS_INC(12352000) :
                              tx_idx == 3'h2 ? `COS_INC(8192000) :
                              tx_idx == 3'h3 ? `COS_INC(6176000) :
                              tx_idx == 3'h4 ? `COS_INC(4096000) :
                              tx_idx == 3'h5 ? `COS_INC(3088000) :
                              tx_idx == 3'h6 ? `COS_INC(2048000) :
                              `COS_INC(1544000);

    assign rx_if.increment = rx_base_inc + gcm_trim;
    assign tx_if.increment = tx_base_inc + gcm_trim;
    assign e1_if.increment = `COS_INC(2048000);
    assign t1_if.increment = `COS_INC(1544000);
    assign tx_if.phase_clear = 1'b0;
    assign e1_if.phase_clear = 1'b0;
    assign t1_if.phase_clear = 1'b0;

    // ****************************************************************
    // Sync input: activity detection and phase lock.
    // ****************************************************************
    logic sync_meta_reg;
    logic sync_sync_reg;
    logic sync_prev_reg;
    logic [ACT_W-1:0] act_cnt_reg;
    logic [ACT_W-1:0] act_cnt_next;

    wire sync_edge = sync_sync_reg ^ sync_prev_reg;
    wire sync_rise = sync_sync_reg & ~sync_prev_reg;
    // A pin left open sits high and never toggles, so it never counts as a reference.
    wire sync_active = act_cnt_reg != '0;
    wire lock_enable = ~oscillator_lock_disable & ~oscillator_lock_source &
                       (~sync_8k_select | master_mode_select);

    assign act_cnt_next = sync_edge ? ACT_W'(SYNC_TIMEOUT_CYC) :
                          sync_active ? act_cnt_reg - ACT_W'(1) : act_cnt_reg;

    // Lock is a phase realignment on every rising reference edge once sync is active; between edges the oscillator coasts.
    assign rx_if.phase_clear = lock_enable & sync_active & sync_rise;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_meta_reg <= 1'b1;
            sync_sync_reg <= 1'b1;
            sync_prev_reg <= 1'b1;
            act_cnt_reg <= '0;
        end else begin
            sync_meta_reg <= sync_in;
            sync_sync_reg <= sync_meta_reg;
            sync_prev_reg <= sync_sync_reg;
            act_cnt_reg <= act_cnt_next;
        end
    end

    // ****************************************************************
    // Dejittered clock outputs.
    // ****************************************************************
    wire rx_osc_active = ~(rx_buffer_size == 2'h3 && !rx_clock_source_hi);
    wire tx_osc_active = ~(tx_buffer_size == 2'h0 && tx_jitter_atten_off);
    // Held high while idle, which matches what the weak pull-up would show.
    wire rx_clk_next = (rx_port_enable & rx_osc_active) ? rx_if.level : 1'b1;
    wire tx_clk_next = (tx_port_enable & tx_osc_active) ? tx_if.level : 1'b1;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_dejitter_clock_out <= 1'b1;
            tx_dejitter_clock_out <= 1'b1;
        end else begin
            rx_dejitter_clock_out <= rx_clk_next;
            tx_dejitter_clock_out <= tx_clk_next;
        end
    end

    // ****************************************************************
    // One-second timer and shared pin.
    // ****************************************************************
    cos_clock_pkg::cos_pin_fn_e pin_fn;
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic [1:0] hi_cnt_reg;
    logic [SEC_W-1:0] sec_cnt_reg;
    logic [1:0] sec_pulse_reg;
    logic [7:0] fr_cnt_reg;
    logic fr_hold_reg;

    assign pin_fn = pin_reg == 2'h1 ? cos_clock_pkg::COS_PIN_SEC_OUT :
                    pin_reg == 2'h2 ? cos_clock_pkg::COS_PIN_FRAME_SYNC :
                    cos_clock_pkg::COS_PIN_TIMER_IN;

    wire tick = e1_if.rise;
    wire pin_is_input = pin_fn == cos_clock_pkg::COS_PIN_TIMER_IN;
    // Only an input pin can restart the timer, so the pin's own pulses never feed back.
    wire sec_restart = pin_is_input & pin_sync_reg & tick & (hi_cnt_reg == 2'h1);
    // A restart on the boundary tick wins, so a cut second never emits a tick or a pulse.
    wire sec_wrap = tick & ~sec_restart & (sec_cnt_reg == SEC_W'(SEC_TICKS - 1));
    wire sec_pulse_on = sec_pulse_reg != 2'h0;

    wire [1:0] hi_cnt_next = !pin_sync_reg ? 2'h0 :
                             (tick && hi_cnt_reg != 2'h2) ? hi_cnt_reg + 2'h1 : hi_cnt_reg;
    wire [SEC_W-1:0] sec_cnt_next = (sec_restart | sec_wrap) ? '0 :
                                    tick ? sec_cnt_reg + SEC_W'(1) : sec_cnt_reg;
    wire [1:0] sec_pulse_next = sec_wrap ? `COS_SEC_PULSE_TICKS :
                                (tick && sec_pulse_on) ? sec_pulse_reg - 2'h1 : sec_pulse_reg;

    wire fr_tick = t1_mode ? t1_if.rise : e1_if.rise;
    wire [7:0] fr_last = t1_mode ? `COS_T1_FRAME_TICKS : `COS_E1_FRAME_TICKS;
    wire fr_wrap = fr_tick & (fr_cnt_reg == fr_last);
    wire [7:0] fr_cnt_next = fr_wrap ? 8'h00 : fr_tick ? fr_cnt_reg + 8'h01 : fr_cnt_reg;
    wire fr_hold_next = fr_wrap ? 1'b1 : fr_tick ? 1'b0 : fr_hold_reg;
    wire frame_sync_pulse_out = fr_hold_reg ^ frame_sync_active_low;

    wire pin_out_next = pin_fn == cos_clock_pkg::COS_PIN_SEC_OUT ? sec_pulse_on :
                        pin_fn == cos_clock_pkg::COS_PIN_FRAME_SYNC ? frame_sync_pulse_out :
                        1'b0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
            hi_cnt_reg <= 2'h0;
            sec_cnt_reg <= '0;
            sec_pulse_reg <= 2'h0;
            fr_cnt_reg <= 8'h00;
            fr_hold_reg <= 1'b0;
        end else begin
            pin_meta_reg <= second_timer_pin_in;
            pin_sync_reg <= pin_meta_reg;
            hi_cnt_reg <= hi_cnt_next;
            sec_cnt_reg <= sec_cnt_next;
            sec_pulse_reg <= sec_pulse_next;
            fr_cnt_reg <= fr_cnt_next;
            fr_hold_reg <= fr_hold_next;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            second_timer_pin_oe <= 1'b0;
            second_timer_pin_out <= 1'b0;
            one_second_tick <= 1'b0;
        end else begin
            second_timer_pin_oe <= ~pin_is_input;
            second_timer_pin_out <= pin_out_next;
            one_second_tick <= sec_wrap;
        end
    end

    assign status_word = {27'h0, pin_sync_reg, tx_osc_active, rx_osc_active,
                          lock_enable & sync_active, sync_active};

    // ****************************************************************
    // Checks.
    // ****************************************************************
    logic [2:0] out_ticks_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_ticks_reg <= 3'h0;
        end else if (!sec_pulse_on) begin
            out_ticks_reg <= 3'h0;
        end else if (tick && out_ticks_reg != 3'h7) begin
            out_ticks_reg <= out_ticks_reg + 3'h1;
        end
    end

    a_rx_clock_idle: assert property (@(posedge clk) disable iff (!arst_n)
        !rx_osc_active |=> rx_dejitter_clock_out)
        else $error("receive clock output toggles while its oscillator is inactive");

    a_tx_clock_idle: assert property (@(posedge clk) disable iff (!arst_n)
        !tx_osc_active |=> tx_dejitter_clock_out)
        else $error("transmit clock output toggles while its oscillator is unused");

    a_clock_enable_gate: assert property (@(posedge clk) disable iff (!arst_n)
        (!rx_port_enable && !tx_port_enable) [*2] |-> rx_dejitter_clock_out && tx_dejitter_clock_out)
        else $error("clock output active without port enable");

    a_pin_input_default: assert property (@(posedge clk) disable iff (!arst_n)
        (pin_reg == 2'h0 || pin_reg == 2'h3) |=> !second_timer_pin_oe)
        else $error("timer pin driven while configured as input");

    a_sec_pulse_width: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(sec_pulse_on) |-> out_ticks_reg == 3'h2)
        else $error("one-second pulse not two timebase cycles long");

    a_sec_pulse_start: assert property (@(posedge clk) disable iff (!arst_n)
        sec_wrap |=> sec_pulse_reg == 2'h2 ##1 sec_pulse_on)
        else $error("one-second pulse did not start on the second boundary");

    a_timer_restart: assert property (@(posedge clk) disable iff (!arst_n)
        sec_restart |=> sec_cnt_reg == '0 && !one_second_tick)
        else $error("timer did not restart on a qualified input pulse");

    a_one_function: assert property (@(posedge clk) disable iff (!arst_n)
        second_timer_pin_oe && $stable(pin_reg) |-> !sec_restart)
        else $error("timer pin used as input while driving");

    a_frame_width: assert property (@(posedge clk) disable iff (!arst_n)
        fr_hold_reg && fr_tick |=> !fr_hold_reg)
        else $error("frame sync pulse longer than one line cycle");

    a_lock_align: assert property (@(posedge clk) disable iff (!arst_n)
        sync_rise && sync_active && lock_enable |-> rx_if.phase_clear)
        else $error("receive oscillator missed a reference edge");

    a_sync_8k_gate: assert property (@(posedge clk) disable iff (!arst_n)
        sync_8k_select && !master_mode_select |-> !rx_if.phase_clear)
        else $error("8 kHz lock outside master mode");

    a_free_run: assert property (@(posedge clk) disable iff (!arst_n)
        !sync_active |-> !rx_if.phase_clear)
        else $error("receive oscillator disturbed without sync activity");

    a_e1_rate_set: assert property (@(posedge clk) disable iff (!arst_n)
        !t1_mode |-> (rx_idx[0] == 1'b0 || rx_idx == 4'h8))
        else $error("T1 rate selected in E1 mode");
endmodule : cos_clock_outputs

// ### design/cos_nco.sv
`timescale 1ns/1ps
// ****************************************************************
// Phase accumulator oscillator running on the reference clock.
// ****************************************************************
module cos_nco (
    input wire logic clk,
    input wire logic arst_n,
    cos_nco_if.core nco
);
    cos_clock_pkg::cos_inc_t acc_reg;
    cos_clock_pkg::cos_inc_t acc_next;
    logic level_reg;
    logic rise_reg;

    // Clearing loads the increment so the first step after alignment is not lost.
    assign acc_next = nco.phase_clear ? nco.increment : acc_reg + nco.increment;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_reg <= 32'h0;
            level_reg <= 1'b0;
            rise_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            level_reg <= acc_next[31];
            rise_reg <= acc_next[31] & ~level_reg;
        end
    end

    assign nco.level = level_reg;
    assign nco.rise = rise_reg;
endmodule : cos_nco

// ### shared/cos_clock_pkg.sv
package cos_clock_pkg;
    typedef enum logic [1:0] {
        COS_PIN_TIMER_IN,
        COS_PIN_SEC_OUT,
        COS_PIN_FRAME_SYNC
    } cos_pin_fn_e;
    typedef logic [31:0] cos_inc_t;
endpackage : cos_clock_pkg

// ### shared/cos_clock_regs.svh
`ifndef COS_CLOCK_REGS_SVH
`define COS_CLOCK_REGS_SVH

// ****************************************************************
// Register map.
// ****************************************************************
`define COS_OFF_CTRL 8'h00
`define COS_OFF_BUF 8'h04
`define COS_OFF_PORT 8'h08
`define COS_OFF_PIN 8'h0c
`define COS_OFF_GCM 8'h10
`define COS_OFF_STAT 8'h14

`define COS_CTRL_MASTER 0
`define COS_CTRL_SYNC8K 1
`define COS_CTRL_LOCK_DIS 2
`define COS_CTRL_LOCK_SRC 3
`define COS_CTRL_T1 4
`define COS_CTRL_RS_HI 5
`define COS_CTRL_XJA_OFF 6
`define COS_CTRL_FS_POL 7

`define COS_PORT_RX_EN 0
`define COS_PORT_RX_RATE_LSB 4
`define COS_PORT_TX_EN 8
`define COS_PORT_TX_RATE_LSB 9

`define COS_RST_CTRL 8'h00
`define COS_RST_BUF 4'h0
`define COS_RST_PORT 11'h000
`define COS_RST_PIN 2'h0
`define COS_RST_GCM 6'h00

// ****************************************************************
// Timing.
// ****************************************************************
`define COS_MCLK_HZ 100000000
`define COS_CLK_PERIOD_NS 10
`define COS_SYNC_TIMEOUT_NS 250000
`define COS_SYNC_TIMEOUT_CYC ((`COS_SYNC_TIMEOUT_NS + `COS_CLK_PERIOD_NS - 1) / `COS_CLK_PERIOD_NS)
`define COS_SEC_TICKS 2048000
`define COS_SEC_PULSE_TICKS 2'h2
`define COS_E1_FRAME_TICKS 8'hff
`define COS_T1_FRAME_TICKS 8'hc0
`define COS_INC(f) (32'(((64'(f)) << 32) / 64'(`COS_MCLK_HZ)))

`endif

// ### shared/cos_nco_if.sv
`timescale 1ns/1ps
interface cos_nco_if;
    cos_clock_pkg::cos_inc_t increment;
    logic phase_clear;
    logic level;
    logic rise;
    modport core (input increment, input phase_clear, output level, output rise);
    modport user (output increment, output phase_clear, input level, input rise);
endinterface : cos_nco_if

// ### verification/cos_clock_outputs_tb.sv
`timescale 1ns/1ps
`include "cos_clock_regs.svh"
module cos_clock_outputs_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic sync_on = 1'b0;
    logic [31:0] rd_data;
    logic sync_in, pin_level, pin_out, pin_oe, rx_clk, tx_clk, tick;
    int bad_count = 0;
    int tests_run = 0;
    int n;
    logic [7:0] fs_ctrl [3] = '{8'h00, 8'h80, 8'h10};
    logic [7:0] lk_ctrl [4] = '{8'h02, 8'h03, 8'h04, 8'h08};
    logic [1:0] lk_exp [4] = '{2'h1, 2'h3, 2'h1, 2'h1};
    cos_clock_outputs #(.SEC_TICKS(64), .SYNC_TIMEOUT_CYC(200)) cos_clock_outputs_i (.clk(clk), .arst_n(arst_n),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sync_in(sync_in),
        .second_timer_pin_in(pin_level), .second_timer_pin_out(pin_out), .second_timer_pin_oe(pin_oe),
        .rx_dejitter_clock_out(rx_clk), .tx_dejitter_clock_out(tx_clk), .one_second_tick(tick));
    cos_timing_partner cos_timing_partner_i (.sync_on(sync_on), .pin_out(pin_out), .pin_oe(pin_oe),
        .sync_in(sync_in), .pin_level(pin_level));
    initial forever #5 clk = ~clk;
    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask : rd
    // Edges jitter by one reference cycle, so callers compare counts against a small window.
    task automatic count_rises(input int cycles, output int nrx, output int ntx);
        logic prx, ptx;
        nrx = 0;
        ntx = 0;
        prx = rx_clk;
        ptx = tx_clk;
        repeat (cycles) begin
            @(posedge clk);
            #1;
            nrx += int'(rx_clk && !prx);
            ntx += int'(tx_clk && !ptx);
            prx = rx_clk;
            ptx = tx_clk;
        end
    endtask : count_rises
    task automatic wait_sig(ref logic s, input logic v, input int lim);
        for (n = 0; n < lim && s !== v; n++) begin
            @(posedge clk);
            #1;
        end
        chk(32'(s), 32'(v));
        if (s !== v) conclude();
    endtask : wait_sig
    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        logic [31:0] d;
        int a, b, i;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk(32'(rx_clk), 32'h1);
        chk(32'(tx_clk), 32'h1);
        chk(32'(pin_oe), 32'h0);
        rd(`COS_OFF_PIN, d);
        chk(d, 32'h0);
        wr(8'h20, 32'hffffffff);
        rd(8'h20, d);
        chk(d, 32'h0);
        wr(`COS_OFF_PIN, 32'h3);
        rd(`COS_OFF_PIN, d);
        chk(d, 32'h3);
        wr(`COS_OFF_GCM, 32'h2a);
        rd(`COS_OFF_GCM, d);
        chk(d, 32'h2a);
        $display("test registers done");
        wr(`COS_OFF_PORT, 32'h161);
        count_rises(4000, a, b);
        chk_rng(a, 80, 84);
        chk_rng(b, 653, 658);
        wr(`COS_OFF_CTRL, 32'h10);
        wr(`COS_OFF_PORT, 32'h111);
        count_rises(4000, a, b);
        chk_rng(a, 492, 496);
        chk_rng(b, 492, 496);
        wr(`COS_OFF_BUF, 32'h3);
        wr(`COS_OFF_CTRL, 32'h40);
        repeat (3) @(posedge clk);
        count_rises(1000, a, b);
        chk(32'(a + b), 32'h0);
        chk(32'({rx_clk, tx_clk}), 32'h3);
        wr(`COS_OFF_CTRL, 32'h20);
        count_rises(1000, a, b);
        chk_rng(a, 1, 1000);
        chk_rng(b, 1, 1000);
        $display("test clock outputs done");
        wr(`COS_OFF_BUF, 32'h0);
        wr(`COS_OFF_CTRL, 32'h0);
        sync_on <= 1'b1;
        repeat (500) @(posedge clk);
        rd(`COS_OFF_STAT, d);
        chk(32'(d[4:0]), 32'h0f);
        for (i = 0; i < 4; i++) begin
            wr(`COS_OFF_CTRL, {24'h0, lk_ctrl[i]});
            rd(`COS_OFF_STAT, d);
            chk(32'(d[1:0]), {30'h0, lk_exp[i]});
        end
        sync_on <= 1'b0;
        repeat (300) @(posedge clk);
        rd(`COS_OFF_STAT, d);
        chk(32'(d[4:0]), 32'h0c);
        $display("test sync done");
        wr(`COS_OFF_PIN, 32'h0);
        #1 chk(32'(pin_oe), 32'h0);
        cos_timing_partner_i.pulse_pin(1500);
        for (n = 0; n < 4000 && tick !== 1'b1; n++) @(posedge clk);
        chk_rng(n, 2900, 3250);
        $display("test timer restart done");
        wr(`COS_OFF_PIN, 32'h1);
        wait_sig(tick, 1'b1, 4000);
        a = 0;
        repeat (150) begin
            @(posedge clk);
            #1 a += int'(pin_oe && pin_out);
        end
        chk_rng(a, 96, 100);
        chk(32'(pin_oe), 32'h1);
        $display("test second output done");
        wr(`COS_OFF_PIN, 32'h2);
        for (i = 0; i < 3; i++) begin
            wr(`COS_OFF_CTRL, {24'h0, fs_ctrl[i]});
            wait_sig(pin_level, fs_ctrl[i][7], 13000);
            wait_sig(pin_level, !fs_ctrl[i][7], 13000);
            for (a = 0; a < 200 && pin_level === !fs_ctrl[i][7]; a++) begin
                @(posedge clk);
                #1;
            end
            chk_rng(a, fs_ctrl[i][4] ? 63 : 47, fs_ctrl[i][4] ? 67 : 51);
        end
        $display("test frame sync done");
        conclude();
    end
endmodule : cos_clock_outputs_tb

// ### verification/cos_timing_partner.sv
`timescale 1ns/1ps
// ****************************************************************
// Board timing source: sync clock and second-timer pulses.
// ****************************************************************
module cos_timing_partner (
    input wire logic sync_on,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic sync_in,
    output logic pin_level
);
    logic ext_val = 1'b0;
    // Our driver holds the pin low between pulses, so a pulled-up idle never looks like a restart.
    assign pin_level = pin_oe ? pin_out : ext_val;
    initial sync_in = 1'b1;
    always begin
        wait (sync_on);
        #244.140 if (sync_on) sync_in = ~sync_in;
    end
    always @(negedge sync_on) sync_in = 1'b1;
    task automatic pulse_pin(input int ns);
        ext_val = 1'b1;
        #(ns) ext_val = 1'b0;
    endtask : pulse_pin
endmodule : cos_timing_partner
